/* rtl/ipr_controller.sv */
// interrupt priority resolution, reset cause capture and apb registers
`timescale 1ns/10ps
`default_nettype none
module ipr_controller #(
  parameter bit HAS_UART_TWO = 1'b1
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [53:0] IRQ_EVENT,
  input  wire logic [3:0]  CPU_LEVEL,
  input  wire logic        IRQ_ACK,
  input  wire logic        IRQ_DONE,
  output logic             IRQ_REQ,
  output logic      [5:0]  IRQ_VECTOR,
  output logic      [2:0]  IRQ_LEVEL,
  input  wire logic        WDT_TIMEOUT,
  input  wire logic        UNINIT_PTR_USE,
  input  wire logic        ILLEGAL_EXEC,
  input  wire logic        ILLEGAL_FLUSHED,
  input  wire logic        BROWNOUT_PIN,
  input  wire logic [3:0]  TRAP_EVENT,
  output logic             CORE_RESET,
  output logic      [23:0] RESET_PC
);

  localparam int N = ipr_pkg::NUM_IRQ;

  logic [63:0] flag;
  logic [63:0] enable;
  logic [2:0]  prio [0:N-1];
  logic        nesting_disable;
  logic        in_service;
  logic [ipr_pkg::CAUSE_BITS-1:0] cause;
  logic        bo_meta;
  logic        bo_sync;
  logic [63:0] live;
  logic [63:0] pend;
  logic        access;
  logic        wr_en;
  logic [31:0] rdata;
  logic        unmapped;
  logic [63:0] wr_clr;
  logic        win_found;
  logic [5:0]  win_idx;
  logic [2:0]  win_lvl;
  logic        next_req;
  logic [ipr_pkg::CAUSE_BITS-1:0] err_evt;
  logic        lockout;

  // populated slots of this variant
  assign live = ipr_pkg::POPULATED |
                (HAS_UART_TWO ? ipr_pkg::UART_TWO_SLOTS : 64'h0);
  assign pend = flag & enable;

  // register word index of a priority register, or 7 when not one
  function automatic logic [2:0] prio_word(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - ipr_pkg::OFS_PRIO_BASE;
    if (addr >= ipr_pkg::OFS_PRIO_BASE && d[7:2] < 6'(ipr_pkg::PRIO_REGS) && d[1:0] == 2'h0)
      prio_word = d[4:2];
    else
      prio_word = 3'h7;
  endfunction

  // apb slave, one wait state
  assign access = PSEL & PENABLE;
  assign wr_en = access & PWRITE & PREADY;

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= access & ~PREADY;
      if (access & ~PREADY) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rdata;
        PSLVERR <= unmapped;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    unmapped = 1'b0;
    case (PADDR)
      ipr_pkg::OFS_FLAG_LO: rdata = flag[31:0];
      ipr_pkg::OFS_FLAG_HI: rdata = flag[63:32];
      ipr_pkg::OFS_EN_LO:   rdata = enable[31:0];
      ipr_pkg::OFS_EN_HI:   rdata = enable[63:32];
      ipr_pkg::OFS_CTRL:    rdata = {31'h0, nesting_disable};
      ipr_pkg::OFS_STATUS:  rdata = {16'h0, IRQ_REQ, in_service, 3'h0,
                                     IRQ_LEVEL, 2'h0, IRQ_VECTOR};
      ipr_pkg::OFS_CAUSE:   rdata = {{(32 - ipr_pkg::CAUSE_BITS){1'b0}}, cause};
      default: begin
        if (prio_word(PADDR) != 3'h7) begin
          for (int j = 0; j < 8; j++) begin
            if (int'(prio_word(PADDR)) * 8 + j < N)
              rdata[j*4 +: 4] = {1'b0, prio[int'(prio_word(PADDR)) * 8 + j]};
          end
        end else begin
          unmapped = 1'b1;
        end
      end
    endcase
  end

  // write-one-to-clear mask for flags
  always_comb begin
    wr_clr = 64'h0;
    if (wr_en && PADDR == ipr_pkg::OFS_FLAG_LO)
      wr_clr[31:0] = PWDATA;
    if (wr_en && PADDR == ipr_pkg::OFS_FLAG_HI)
      wr_clr[63:32] = PWDATA;
  end

  // flags set on events whatever the enable; set wins over clear
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N)
      flag <= 64'h0;
    else
      flag <= ((flag & ~wr_clr) | {10'h0, IRQ_EVENT}) & live;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      enable <= 64'h0;
    end else if (wr_en) begin
      if (PADDR == ipr_pkg::OFS_EN_LO)
        enable[31:0] <= PWDATA & live[31:0];
      if (PADDR == ipr_pkg::OFS_EN_HI)
        enable[63:32] <= PWDATA & live[63:32];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      for (int i = 0; i < N; i++)
        prio[i] <= live[i] ? ipr_pkg::PRIO_RESET : 3'h0;
    end else if (wr_en && prio_word(PADDR) != 3'h7) begin
      for (int j = 0; j < 8; j++) begin
        if (int'(prio_word(PADDR)) * 8 + j < N && live[int'(prio_word(PADDR)) * 8 + j])
          prio[int'(prio_word(PADDR)) * 8 + j] <= PWDATA[j*4 +: 3];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N)
      nesting_disable <= 1'b0;
    else if (wr_en && PADDR == ipr_pkg::OFS_CTRL)
      nesting_disable <= PWDATA[ipr_pkg::CTRL_NEST_DIS];
  end

  // handler running between core acknowledge and return
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N)
      in_service <= 1'b0;
    else if (IRQ_ACK)
      in_service <= 1'b1;
    else if (IRQ_DONE)
      in_service <= 1'b0;
  end

  // scan from the top down so that equal levels keep the lower number
  always_comb begin
    win_found = 1'b0;
    win_idx = 6'h00;
    win_lvl = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i] && prio[i] != 3'h0 && prio[i] >= win_lvl) begin
        win_found = 1'b1;
        win_idx = 6'(i);
        win_lvl = prio[i];
      end
    end
  end

  always_comb begin
    next_req = win_found && ({1'b0, win_lvl} > CPU_LEVEL);
    if (nesting_disable && in_service)
      next_req = 1'b0;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      IRQ_REQ <= 1'b0;
      IRQ_VECTOR <= 6'h00;
      IRQ_LEVEL <= 3'h0;
    end else begin
      IRQ_REQ <= next_req;
      IRQ_VECTOR <= win_idx + 6'(ipr_pkg::VEC_OFFSET);
      IRQ_LEVEL <= win_lvl;
    end
  end

  // brown-out comes from the analog side
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      bo_meta <= 1'b0;
      bo_sync <= 1'b0;
    end else begin
      bo_meta <= BROWNOUT_PIN;
      bo_sync <= bo_meta;
    end
  end

  assign lockout = (TRAP_EVENT & (TRAP_EVENT - 4'h1)) != 4'h0;

  always_comb begin
    err_evt = '0;
    err_evt[ipr_pkg::CAUSE_WDT] = WDT_TIMEOUT;
    err_evt[ipr_pkg::CAUSE_UNINIT] = UNINIT_PTR_USE;
    err_evt[ipr_pkg::CAUSE_ILLEGAL] = ILLEGAL_EXEC & ~ILLEGAL_FLUSHED;
    err_evt[ipr_pkg::CAUSE_BROWNOUT] = bo_sync;
    err_evt[ipr_pkg::CAUSE_LOCKOUT] = lockout;
  end

  // sticky causes, write one to clear, new event wins
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N)
      cause <= '0;
    else if (wr_en && PADDR == ipr_pkg::OFS_CAUSE)
      cause <= (cause & ~PWDATA[ipr_pkg::CAUSE_BITS-1:0]) | err_evt;
    else
      cause <= cause | err_evt;
  end

  // error conditions send the core to the reset vector
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      CORE_RESET <= 1'b0;
      RESET_PC <= ipr_pkg::RESET_PC;
    end else begin
      CORE_RESET <= |err_evt;
      RESET_PC <= ipr_pkg::RESET_PC;
    end
  end

endmodule
`default_nettype wire

/* rtl/ipr_pkg.sv */
// constants for the interrupt priority and reset entry block
// Operation
// - 3-bit priority in nibble, bit3 reads zero
// - priority 0 lowest, 7 highest
// - natural order only breaks equal priority
// - number 0 wins ties, 53 loses
// - vector equals interrupt number plus eight
// - numbers 0..16 map the listed sources
// - 23,24,25,42 populated; others reserved
// - second uart slots only in that variant
// - reset forces program counter to zero
// - first location jumps to start address
// - five error conditions route to reset
// - watchdog timeout causes reset
// - uninitialised pointer use causes reset
// - executed illegal opcode traps; flushed one not
// - brown-out dip causes reset
// - simultaneous traps cause lockout reset
// - priority zero source is disabled
// - flag sets regardless of enable; software clears
// - nesting disable blocks new interrupt in service
package ipr_pkg;
  localparam int NUM_IRQ = 54;
  localparam int VEC_OFFSET = 8;
  localparam int PRIO_REGS = 7;
  localparam logic [63:0] POPULATED = 64'h0000_0400_0081_FFFF;
  localparam logic [63:0] UART_TWO_SLOTS = 64'h0000_0000_0300_0000;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [23:0] RESET_PC = 24'h00_0000;
  localparam logic [7:0] OFS_FLAG_LO = 8'h00;
  localparam logic [7:0] OFS_FLAG_HI = 8'h04;
  localparam logic [7:0] OFS_EN_LO = 8'h08;
  localparam logic [7:0] OFS_EN_HI = 8'h0C;
  localparam logic [7:0] OFS_PRIO_BASE = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  localparam logic [7:0] OFS_CAUSE = 8'h38;
  localparam int CTRL_NEST_DIS = 0;
  localparam int CAUSE_WDT = 0;
  localparam int CAUSE_UNINIT = 1;
  localparam int CAUSE_ILLEGAL = 2;
  localparam int CAUSE_BROWNOUT = 3;
  localparam int CAUSE_LOCKOUT = 4;
  localparam int CAUSE_BITS = 5;
endpackage

/* verification/ipr_controller_sva.sv */
// assertion checker for the interrupt priority block
`timescale 1ns/10ps
`default_nettype none
module ipr_controller_sva (
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic [3:0]  CPU_LEVEL,
  input wire logic        IRQ_REQ,
  input wire logic [5:0]  IRQ_VECTOR,
  input wire logic [2:0]  IRQ_LEVEL,
  input wire logic        WDT_TIMEOUT,
  input wire logic        UNINIT_PTR_USE,
  input wire logic        ILLEGAL_EXEC,
  input wire logic        ILLEGAL_FLUSHED,
  input wire logic [3:0]  TRAP_EVENT,
  input wire logic        CORE_RESET,
  input wire logic [23:0] RESET_PC
);
  localparam logic [63:0] POP = ipr_pkg::POPULATED | ipr_pkg::UART_TWO_SLOTS;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  reset_pc_a: assert property (RESET_PC == 24'h00_0000)
    else $error("reset pc not zero");
  vec_range_a: assert property (IRQ_REQ |-> IRQ_VECTOR >= 6'h08 && IRQ_VECTOR <= 6'h3D)
    else $error("vector out of range");
  vec_slot_a: assert property (IRQ_REQ |-> POP[IRQ_VECTOR - 6'h08])
    else $error("vector of reserved slot");
  level_above_a: assert property (IRQ_REQ && $stable(CPU_LEVEL) |-> {1'b0, IRQ_LEVEL} > CPU_LEVEL)
    else $error("request not above core level");
  wdt_reset_a: assert property (WDT_TIMEOUT |=> CORE_RESET)
    else $error("watchdog gave no reset");
  uninit_reset_a: assert property (UNINIT_PTR_USE |=> CORE_RESET)
    else $error("pointer fault gave no reset");
  illegal_reset_a: assert property (ILLEGAL_EXEC && !ILLEGAL_FLUSHED |=> CORE_RESET)
    else $error("illegal opcode gave no reset");
  lockout_reset_a: assert property ($countones(TRAP_EVENT) > 1 |=> CORE_RESET)
    else $error("trap lockout gave no reset");
endmodule
bind ipr_controller ipr_controller_sva ipr_controller_sva_inst (.*);
`default_nettype wire

/* verification/ipr_core_model.sv */
// core model: acknowledges requests and returns from handlers on command
`timescale 1ns/10ps
`default_nettype none
module ipr_core_model (
  input  wire logic clk,
  input  wire logic req,
  input  wire logic serve,
  input  wire logic ret,
  output logic      ack,
  output logic      done
);
  // ack pulses on every other cycle while a request stands and serve is high
  always_ff @(posedge clk) begin
    ack  <= req && serve && !ack;
    done <= ret && !done;
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the interrupt priority block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h seen %h", n, e, s); end end
module tb;
  typedef struct packed {
    logic [31:0] pr;
    logic [53:0] ev;
    logic [3:0]  lv;
    logic        rq;
    logic [5:0]  vc;
  } ipr_row_s;
  logic SYS_CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, IRQ_ACK, IRQ_DONE, IRQ_REQ, CORE_RESET, err, serve = 1'b0, ret = 1'b0;
  logic [53:0] IRQ_EVENT = 54'h0;
  logic [3:0]  CPU_LEVEL = 4'h0, TRAP_EVENT = 4'h0;
  logic [5:0]  IRQ_VECTOR;
  logic [2:0]  IRQ_LEVEL;
  logic [23:0] RESET_PC;
  logic WDT_TIMEOUT = 1'b0, UNINIT_PTR_USE = 1'b0, ILLEGAL_EXEC = 1'b0;
  logic ILLEGAL_FLUSHED = 1'b0, BROWNOUT_PIN = 1'b0;
  int bad_count = 0, samples_checked = 0;
  ipr_row_s rows [11] = '{
    '{32'h4444_4444, 54'h8, 4'h0, 1'b1, 6'h0B}, '{32'h4444_4444, 54'h24, 4'h0, 1'b1, 6'h0A},
    '{32'h4447_4444, 54'h11, 4'h0, 1'b1, 6'h0C}, '{32'h4444_4440, 54'h1, 4'h0, 1'b0, 6'h00},
    '{32'h4444_4441, 54'h3, 4'h0, 1'b1, 6'h09}, '{32'h4444_4444, 54'h80_0000, 4'h0, 1'b1, 6'h1F},
    '{32'h4444_4444, 54'h2_0000, 4'h0, 1'b0, 6'h00},
    '{32'h4444_4444, 54'h400_0000_0000, 4'h0, 1'b1, 6'h32},
    '{32'h4444_4444, 54'h100_0000, 4'h0, 1'b1, 6'h20},
    '{32'h4444_4444, 54'h8, 4'h4, 1'b0, 6'h00}, '{32'h4444_4444, 54'h8, 4'h3, 1'b1, 6'h0B}};
  ipr_controller ipr_controller_inst (.*);
  ipr_core_model ipr_core_model_inst (.clk(SYS_CLK), .req(IRQ_REQ), .serve(serve), .ret(ret),
    .ack(IRQ_ACK), .done(IRQ_DONE));
  always #4 SYS_CLK = ~SYS_CLK;
  task automatic tick(input int k);
    repeat (k) @(posedge SYS_CLK);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n == 20) bad_count++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic drive_err(input logic [4:0] e, input logic fl);
    WDT_TIMEOUT <= e[0];
    UNINIT_PTR_USE <= e[1];
    ILLEGAL_EXEC <= e[2];
    BROWNOUT_PIN <= e[3];
    TRAP_EVENT <= e[4] ? 4'h5 : {3'h0, fl};
    ILLEGAL_FLUSHED <= fl;
    @(posedge SYS_CLK);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #60000;
    bad_count++;
    finish_test();
  end
  initial begin
    tick(12);
    `CHK("req in reset", 1'b0, IRQ_REQ)
    `CHK("reset pc", 24'h00_0000, RESET_PC)
    RESET_N <= 1'b1;
    apb(0, 8'h10, 0); `CHK("prio word0", 32'h4444_4444, rd)
    apb(0, 8'h18, 0); `CHK("prio word2", 32'h4000_0004, rd)
    apb(0, 8'h1C, 0); `CHK("prio word3", 32'h0000_0044, rd)
    apb(1, 8'h10, 32'hFFFF_FFFF);
    apb(0, 8'h10, 0); `CHK("prio nibbles", 32'h7777_7777, rd)
    apb(1, 8'h08, 32'h0);
    drive_err(0, 0);
    IRQ_EVENT <= 54'h8;
    @(posedge SYS_CLK) IRQ_EVENT <= 54'h0;
    apb(0, 8'h00, 0); `CHK("flag no enable", 32'h8, rd)
    `CHK("req no enable", 1'b0, IRQ_REQ)
    apb(1, 8'h0C, 32'h003F_FFFF);
    apb(1, 8'h08, 32'hFFFF_FFFF);
    apb(1, 8'h30, 32'h1);
    serve <= 1'b1;
    tick(3);
    serve <= 1'b0;
    tick(3); `CHK("nest blocked", 1'b0, IRQ_REQ)
    ret <= 1'b1;
    @(posedge SYS_CLK) ret <= 1'b0;
    tick(4); `CHK("after return", 1'b1, IRQ_REQ)
    `CHK("return vector", 6'h0B, IRQ_VECTOR)
    `CHK("return level", 3'h7, IRQ_LEVEL)
    apb(1, 8'h30, 32'h0);
    foreach (rows[i]) begin
      apb(1, 8'h00, 32'hFFFF_FFFF);
      apb(1, 8'h04, 32'h003F_FFFF);
      apb(1, 8'h10, rows[i].pr);
      CPU_LEVEL <= rows[i].lv;
      @(posedge SYS_CLK) IRQ_EVENT <= rows[i].ev;
      @(posedge SYS_CLK) IRQ_EVENT <= 54'h0;
      tick(2);
      `CHK("request", rows[i].rq, IRQ_REQ)
      if (rows[i].rq) `CHK("vector", rows[i].vc, IRQ_VECTOR)
    end
    apb(0, 8'hFC, 0); `CHK("unmapped error", 1'b1, err)
    for (int i = 0; i < 5; i++) begin
      drive_err(5'h1 << i, 0);
      drive_err(0, 0); `CHK("core reset", 1'(i != 3), CORE_RESET)
      tick(4);
      apb(0, 8'h38, 0); `CHK("cause", 32'h1 << i, rd)
      apb(1, 8'h38, 32'h1F);
    end
    drive_err(5'h04, 1);
    drive_err(0, 0); `CHK("no reset", 1'b0, CORE_RESET)
    apb(0, 8'h38, 0); `CHK("no cause", 32'h0, rd)
    // second reset in mid-run while a request stands
    RESET_N <= 1'b0;
    tick(2); `CHK("req mid reset", 1'b0, IRQ_REQ)
    RESET_N <= 1'b1;
    apb(0, 8'h08, 0); `CHK("enable after reset", 32'h0, rd)
    apb(0, 8'h10, 0); `CHK("prio after reset", 32'h4444_4444, rd)
    finish_test();
  end
endmodule
`default_nettype wire
